// >>> hw/osr_pkg.sv
// Shared constants and types of the octal shift register block.
package osr_pkg;
	// Data width of the stage chain and of the bidirectional bus.
	localparam int unsigned STAGES = 8;
	// Depth of the capture FIFO.
	localparam int unsigned FIFO_DEPTH = 16;
	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [3:0] OFF_FIFO = 4'h8;
	// Field positions.
	localparam int CTRL_CAP_BIT = 0;
	localparam int STAT_STAGE_POS = 0;
	localparam int STAT_TAPF_BIT = 8;
	localparam int STAT_TAPL_BIT = 9;
	localparam int STAT_OE_BIT = 10;
	localparam int STAT_RDY_BIT = 11;
	localparam int STAT_LEVEL_POS = 16;
	localparam int FIFO_VALID_BIT = 8;
	// Reset values.
	localparam logic CTRL_CAP_RST = 1'b0;
	localparam logic [7:0] STAGE_RST = 8'h00;
	// AXI response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// Variant of the shift register.
	typedef enum logic [1:0] {OSR_LR_ASYNC, OSR_LR_SYNC, OSR_RIGHT_ASYNC} osr_var_e;
	// Clocked operation chosen by the control pins.
	typedef enum logic [1:0] {OSR_HOLD, OSR_SHR, OSR_SHL, OSR_LOAD} osr_mode_e;
endpackage : osr_pkg

// >>> hw/osr_fifo_if.sv
// Interface carrying the capture FIFO's fill and drain signals.
`timescale 1ns/10ps
interface osr_fifo_if #(
	parameter int WIDTH = 8,
	parameter int LW = 5
);
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [WIDTH-1:0] out_data;
	logic [LW-1:0] level;
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data, level);
	modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data, level);
endinterface : osr_fifo_if

// >>> hw/osr_fifo.sv
// Synchronous FIFO with registered read data for captured stage words.
`timescale 1ns/10ps
module osr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	osr_fifo_if.store f
);
	localparam int AW = $clog2(DEPTH);

	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || $bits(f.level) != AW + 1)
			$error("osr_fifo: DEPTH must be a power of two and match the level width");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_r;
	logic [AW-1:0] rptr_r;
	logic [AW:0] count_r;
	logic out_valid_r;
	logic [WIDTH-1:0] out_data_r;

	////////////////////////////////////////////////////////////////////////////////
	// Handshakes and next pointers.
	wire push = f.in_valid && (count_r != AW'(0) ? count_r != (AW + 1)'(DEPTH) : 1'b1);
	wire pop = f.out_ready && out_valid_r;
	wire [AW-1:0] rptr_nxt = pop ? rptr_r + AW'(1) : rptr_r;
	wire [AW:0] count_nxt = count_r + (AW + 1)'(push) - (AW + 1)'(pop);
	wire bypass = push && (wptr_r == rptr_nxt);

	assign f.in_ready = count_r != (AW + 1)'(DEPTH);
	assign f.out_valid = out_valid_r;
	assign f.out_data = out_data_r;
	assign f.level = count_r;

	// Storage array write.
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wptr_r] <= f.in_data;
	end

	// Pointers, fill level and the read-data register.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wptr_r <= '0;
			rptr_r <= '0;
			count_r <= '0;
			out_valid_r <= 1'b0;
			out_data_r <= '0;
		end
		else
		begin
			wptr_r <= push ? wptr_r + AW'(1) : wptr_r;
			rptr_r <= rptr_nxt;
			count_r <= count_nxt;
			out_valid_r <= count_nxt != '0;
			out_data_r <= bypass ? f.in_data : mem[rptr_nxt];
		end
	end
endmodule : osr_fifo

// >>> hw/osr_top.sv
// Octal universal shift register with bus pins, capture FIFO and AXI4-Lite status.
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
// Contract
// - One eight-bit bus serves as parallel load input and stage output.
// - Mode pins alone pick the operation each edge; the bus-drive controls do not affect it.
// - Load mode captures all eight bus bits on the rising edge.
// - Low clear zeroes stages; synchronously in one variant, immediately otherwise.
// - Shift mode moves stages one place per rising edge.
// - Left/right variants shift either way, chosen by mode encoding.
// - Right-only variant fills first stage from fill inputs or itself.
// - Sign extension keeps the first stage while shifting right.
// - Bus lines are three-state so they can share a bus.
// - Either drive control high floats the bus; operation continues.
// - Right-only: clear with enable and select low clears and floats.
module osr_top #(
	parameter osr_pkg::osr_var_e VARIANT = osr_pkg::OSR_LR_ASYNC,
	parameter int FIFO_DEPTH = osr_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear_n,
	input wire logic mode_select_low,
	input wire logic mode_select_high,
	input wire logic bus_drive_ctl_a,
	input wire logic bus_drive_ctl_b,
	input wire logic left_serial_in,
	input wire logic right_serial_in,
	input wire logic reg_enable_n,
	input wire logic serial_select,
	input wire logic sign_extend_n,
	input wire logic data_select,
	input wire logic fill_bit_zero_in,
	input wire logic fill_bit_one_in,
	input wire logic [7:0] bus_in,
	output logic [7:0] bus_out,
	output logic [7:0] bus_oe,
	output logic first_stage_tap,
	output logic last_stage_tap,
	output logic capture_ready,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	initial
	begin
		if (FIFO_DEPTH < 2 || LW > 16)
			$error("osr_top: FIFO_DEPTH out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode decoding.

	// Left/right variants: high/low select pair.
	function automatic osr_pkg::osr_mode_e decode_lr(input logic sel_hi, input logic sel_lo);
		osr_pkg::osr_mode_e m;
		m = osr_pkg::OSR_HOLD;
		unique case ({sel_hi, sel_lo})
			2'b00: m = osr_pkg::OSR_HOLD;
			2'b01: m = osr_pkg::OSR_SHR;
			2'b10: m = osr_pkg::OSR_SHL;
			2'b11: m = osr_pkg::OSR_LOAD;
		endcase
		return m;
	endfunction : decode_lr

	// Right-only variant: register enable and serial/parallel select.
	function automatic osr_pkg::osr_mode_e decode_right(input logic ren_n, input logic ser);
		osr_pkg::osr_mode_e m;
		m = osr_pkg::OSR_HOLD;
		if (!ren_n)
			m = ser ? osr_pkg::OSR_SHR : osr_pkg::OSR_LOAD;
		return m;
	endfunction : decode_right

	wire is_right = VARIANT == osr_pkg::OSR_RIGHT_ASYNC;
	wire is_sync_clear = VARIANT == osr_pkg::OSR_LR_SYNC;

	wire osr_pkg::osr_mode_e mode_w = is_right ? decode_right(reg_enable_n, serial_select)
		: decode_lr(mode_select_high, mode_select_low);

	////////////////////////////////////////////////////////////////////////////////
	// Stage chain.

	logic [7:0] stage_r;
	logic [7:0] stage_nxt;

	wire fill_right = !sign_extend_n ? stage_r[0]
		: (data_select ? fill_bit_one_in : fill_bit_zero_in);
	wire shr_in = is_right ? fill_right : right_serial_in;

	// Next stage contents for each operation.
	always_comb
	begin
		stage_nxt = stage_r;
		unique case (mode_w)
			osr_pkg::OSR_HOLD: stage_nxt = stage_r;
			osr_pkg::OSR_SHR: stage_nxt = {stage_r[6:0], shr_in};
			osr_pkg::OSR_SHL: stage_nxt = is_right ? stage_r : {left_serial_in, stage_r[7:1]};
			osr_pkg::OSR_LOAD: stage_nxt = bus_in;
		endcase
	end

	generate
		if (VARIANT == osr_pkg::OSR_LR_SYNC)
		begin : g_sync_clear
			always_ff @(posedge clk)
			begin
				if (!rst_n || !clear_n)
					stage_r <= osr_pkg::STAGE_RST;
				else
					stage_r <= stage_nxt;
			end
		end
		else
		begin : g_async_clear
			always_ff @(posedge clk or negedge clear_n)
			begin
				if (!clear_n)
					stage_r <= osr_pkg::STAGE_RST;
				else if (!rst_n)
					stage_r <= osr_pkg::STAGE_RST;
				else
					stage_r <= stage_nxt;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Bus drivers and cascade taps.

	wire float_ctl = bus_drive_ctl_a || bus_drive_ctl_b;
	wire float_rclr = is_right && !clear_n && !reg_enable_n && !serial_select;
	// The bus is an input while loading, so the registered driver lets go at the first load edge, after that edge has captured.
	wire drive_nxt = !float_ctl && !float_rclr && mode_w != osr_pkg::OSR_LOAD;

	logic oe_r;

	// Driver enable register.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			oe_r <= 1'b0;
		else
			oe_r <= drive_nxt;
	end

	assign bus_out = stage_r;
	assign bus_oe = {8{oe_r}};
	assign first_stage_tap = stage_r[0];
	assign last_stage_tap = stage_r[7];

	////////////////////////////////////////////////////////////////////////////////
	// Capture FIFO: each clocked operation other than hold or clear is logged when enabled, while the FIFO has room.

	logic cap_en_r;
	logic cap_rdy_r;
	osr_fifo_if #(.WIDTH(8), .LW(LW)) fq ();

	osr_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.f(fq.store)
	);

	wire changes = mode_w != osr_pkg::OSR_HOLD && clear_n;
	assign fq.in_valid = cap_en_r && changes;
	assign fq.in_data = stage_nxt;

	// Ready towards the source, shown on a pin so it can pause its activity.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cap_rdy_r <= 1'b0;
		else
			cap_rdy_r <= fq.in_ready;
	end
	assign capture_ready = cap_rdy_r;

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel.

	logic aw_got_r;
	logic w_got_r;
	logic [3:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;

	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready = !w_got_r && !bvalid_r;
	wire aw_hs = s_axi_awvalid && s_axi_awready;
	wire w_hs = s_axi_wvalid && s_axi_wready;
	wire have_aw = aw_got_r || aw_hs;
	wire have_w = w_got_r || w_hs;
	wire wr_fire = have_aw && have_w;
	wire [3:0] wr_addr = aw_got_r ? aw_addr_r : s_axi_awaddr;
	wire [31:0] wr_data = w_got_r ? w_data_r : s_axi_wdata;
	wire [3:0] wr_strb = w_got_r ? w_strb_r : s_axi_wstrb;
	wire wr_ctrl = wr_fire && wr_addr == osr_pkg::OFF_CTRL;
	wire wr_known = wr_addr == osr_pkg::OFF_CTRL || wr_addr == osr_pkg::OFF_STATUS
		|| wr_addr == osr_pkg::OFF_FIFO;

	// Address and data holding until both have arrived.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end
		else
		begin
			aw_got_r <= have_aw && !wr_fire;
			w_got_r <= have_w && !wr_fire;
			aw_addr_r <= aw_hs ? s_axi_awaddr : aw_addr_r;
			w_data_r <= w_hs ? s_axi_wdata : w_data_r;
			w_strb_r <= w_hs ? s_axi_wstrb : w_strb_r;
		end
	end

	// Write response and the capture enable register.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= osr_pkg::RESP_OKAY;
			cap_en_r <= osr_pkg::CTRL_CAP_RST;
		end
		else
		begin
			bvalid_r <= wr_fire || (bvalid_r && !s_axi_bready);
			bresp_r <= wr_fire ? (wr_known ? osr_pkg::RESP_OKAY : osr_pkg::RESP_DECERR) : bresp_r;
			cap_en_r <= (wr_ctrl && wr_strb[0]) ? wr_data[osr_pkg::CTRL_CAP_BIT] : cap_en_r;
		end
	end
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel.

	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	assign s_axi_arready = !rvalid_r;
	wire ar_hs = s_axi_arvalid && !rvalid_r;
	wire rd_fifo = ar_hs && s_axi_araddr == osr_pkg::OFF_FIFO;
	assign fq.out_ready = rd_fifo;

	// Read data selection.
	logic [31:0] rd_word;
	logic rd_known;
	always_comb
	begin
		rd_word = '0;
		rd_known = 1'b1;
		if (s_axi_araddr == osr_pkg::OFF_CTRL)
			rd_word[osr_pkg::CTRL_CAP_BIT] = cap_en_r;
		else if (s_axi_araddr == osr_pkg::OFF_STATUS)
		begin
			rd_word[osr_pkg::STAT_STAGE_POS +: 8] = stage_r;
			rd_word[osr_pkg::STAT_TAPF_BIT] = stage_r[0];
			rd_word[osr_pkg::STAT_TAPL_BIT] = stage_r[7];
			rd_word[osr_pkg::STAT_OE_BIT] = oe_r;
			rd_word[osr_pkg::STAT_RDY_BIT] = fq.in_ready;
			rd_word[osr_pkg::STAT_LEVEL_POS +: LW] = fq.level;
		end
		else if (s_axi_araddr == osr_pkg::OFF_FIFO)
		begin
			rd_word[7:0] = fq.out_valid ? fq.out_data : 8'h00;
			rd_word[osr_pkg::FIFO_VALID_BIT] = fq.out_valid;
		end
		else
			rd_known = 1'b0;
	end

	// Read answer register.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= osr_pkg::RESP_OKAY;
		end
		else
		begin
			rvalid_r <= ar_hs || (rvalid_r && !s_axi_rready);
			rdata_r <= ar_hs ? rd_word : rdata_r;
			rresp_r <= ar_hs ? (rd_known ? osr_pkg::RESP_OKAY : osr_pkg::RESP_DECERR) : rresp_r;
		end
	end
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_load;
		@(posedge clk) disable iff (!rst_n)
		(rst_n && clear_n && mode_w == osr_pkg::OSR_LOAD) |=> (!clear_n || bus_out == $past(bus_in));
	endproperty
	a_load: assert property (p_load) else $error("load did not capture the bus");

	property p_clear;
		@(posedge clk) disable iff (!rst_n)
		(rst_n && !clear_n) |=> (bus_out == 8'h00);
	endproperty
	a_clear: assert property (p_clear) else $error("clear left a stage set");

	property p_shr;
		@(posedge clk) disable iff (!rst_n)
		(rst_n && clear_n && mode_w == osr_pkg::OSR_SHR)
		|=> (!clear_n || bus_out[7:1] == $past(bus_out[6:0]));
	endproperty
	a_shr: assert property (p_shr) else $error("right shift moved wrong");

	property p_shl;
		@(posedge clk) disable iff (!rst_n)
		(rst_n && clear_n && !is_right && mode_w == osr_pkg::OSR_SHL)
		|=> (!clear_n || bus_out == {$past(left_serial_in), $past(bus_out[7:1])});
	endproperty
	a_shl: assert property (p_shl) else $error("left shift moved wrong");

	property p_sign;
		@(posedge clk) disable iff (!rst_n)
		(rst_n && clear_n && is_right && mode_w == osr_pkg::OSR_SHR && !sign_extend_n)
		|=> (!clear_n || (first_stage_tap == $past(first_stage_tap)
		&& bus_out[1] == $past(first_stage_tap)));
	endproperty
	a_sign: assert property (p_sign) else $error("sign bit not kept");

	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		(rst_n && clear_n && mode_w == osr_pkg::OSR_HOLD) ##1 clear_n |-> $stable(bus_out);
	endproperty
	a_hold: assert property (p_hold) else $error("hold changed the stages");

	property p_float;
		@(posedge clk) disable iff (!rst_n)
		(rst_n && float_ctl) |=> (bus_oe == 8'h00);
	endproperty
	a_float: assert property (p_float) else $error("bus driven while floated");

	property p_drive;
		@(posedge clk) disable iff (!rst_n)
		(rst_n && !float_ctl && clear_n && mode_w == osr_pkg::OSR_HOLD) |=> (bus_oe == 8'hff);
	endproperty
	a_drive: assert property (p_drive) else $error("bus not driven when enabled");

	property p_rclr;
		@(posedge clk) disable iff (!rst_n)
		(rst_n && float_rclr) |=> (bus_oe == 8'h00 && bus_out == 8'h00);
	endproperty
	a_rclr: assert property (p_rclr) else $error("enable-low clear did not float");

	property p_taps;
		@(posedge clk) disable iff (!rst_n)
		(rst_n && float_ctl) |=> (first_stage_tap == bus_out[0] && last_stage_tap == bus_out[7]);
	endproperty
	a_taps: assert property (p_taps) else $error("taps differ from stages");
endmodule : osr_top

// >>> bench/osr_bus_host.sv
// Behavioural model of the processor bus that shares the stage pins.
`timescale 1ns/10ps
module osr_bus_host (
	input wire logic clk,
	input wire logic drv_en,
	input wire logic [7:0] drv_val,
	input wire logic [7:0] dev_out,
	input wire logic [7:0] dev_oe,
	output logic [7:0] bus
);
	logic [7:0] last_r;
	logic [7:0] far_w;
	////////////////////////////////////////////////////////////////////////////////////////
	// A released line shows the inverse of its last level, so nothing stale can pass.
	assign far_w = drv_en ? drv_val : ~last_r;
	assign bus = (dev_oe & dev_out) | (~dev_oe & far_w);
	// Remembers each line's level for the floating pattern.
	always_ff @(posedge clk)
	begin
		last_r <= bus;
	end
endmodule : osr_bus_host

// >>> bench/osr_top_tb.sv
// Self-checking bench for the shift register in its left/right and right-only forms.
`timescale 1ns/10ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
	$display("BAD %s expected %h seen %h", nm, e, s); end end
module osr_top_tb;
	typedef struct {string nm; logic [17:0] lr; logic [17:0] ro;} osr_pin_s;
	typedef struct {string nm; logic [33:0] v;} osr_bus_s;
	logic clk = 1'b0, rst_n = 1'b0, clear_n = 1'b1;
	logic mode_select_low = 1'b0, mode_select_high = 1'b0;
	logic bus_drive_ctl_a = 1'b0, bus_drive_ctl_b = 1'b0;
	logic left_serial_in = 1'b0, right_serial_in = 1'b0, fill_bit_zero_in = 1'b0;
	logic fill_bit_one_in = 1'b0, reg_enable_n = 1'b1, serial_select = 1'b0;
	logic sign_extend_n = 1'b1, data_select = 1'b0, drv_lr = 1'b1, drv_ro = 1'b1;
	logic [7:0] drv_val = 8'h00, lr_bus, lr_out, lr_oe, ro_bus, ro_out, ro_oe;
	logic lr_first, lr_last, ro_first, ro_last;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, r;
	logic [7:0] e_lr = 8'h00, e_ro = 8'h00, e_oe_lr = 8'h00, e_oe_ro = 8'h00;
	logic cap_en = 1'b0;
	logic [7:0] cap_q[$];
	osr_pin_s pin_q[$];
	osr_bus_s b_q[$], r_q[$];
	osr_bus_s an;
	osr_pin_s pn;
	int fail_count = 0, checks_done = 0, seed = 89;
	////////////////////////////////////////////////////////////////////////////////////////
	// Both variants see the same stimulus, each on a bus of its own.
	if (1)
	begin : g_lr
		osr_top #(.VARIANT(osr_pkg::OSR_LR_ASYNC), .FIFO_DEPTH(16)) osr_top_i (.clk, .rst_n,
			.clear_n, .mode_select_low, .mode_select_high, .bus_drive_ctl_a, .bus_drive_ctl_b,
			.left_serial_in, .right_serial_in, .reg_enable_n, .serial_select, .sign_extend_n,
			.data_select, .fill_bit_zero_in, .fill_bit_one_in, .bus_in(lr_bus), .bus_out(lr_out),
			.bus_oe(lr_oe), .first_stage_tap(lr_first), .last_stage_tap(lr_last),
			.capture_ready(), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
			.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
			.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
			.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
		osr_bus_host osr_bus_host_i (.clk, .drv_en(drv_lr), .drv_val, .dev_out(lr_out),
			.dev_oe(lr_oe), .bus(lr_bus));
	end
	if (1)
	begin : g_ro
		osr_top #(.VARIANT(osr_pkg::OSR_RIGHT_ASYNC), .FIFO_DEPTH(16)) osr_top_i (.clk, .rst_n,
			.clear_n, .mode_select_low, .mode_select_high, .bus_drive_ctl_a, .bus_drive_ctl_b,
			.left_serial_in, .right_serial_in, .reg_enable_n, .serial_select, .sign_extend_n,
			.data_select, .fill_bit_zero_in, .fill_bit_one_in, .bus_in(ro_bus), .bus_out(ro_out),
			.bus_oe(ro_oe), .first_stage_tap(ro_first), .last_stage_tap(ro_last),
			.capture_ready(), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
			.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
			.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(),
			.s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready);
		osr_bus_host osr_bus_host_i (.clk, .drv_en(drv_ro), .drv_val, .dev_out(ro_out),
			.dev_oe(ro_oe), .bus(ro_bus));
	end
	////////////////////////////////////////////////////////////////////////////////////////
	// Clock of 100 ns period.
	always #50 clk = ~clk;
	// Pin results settle by the falling edge; every queued note is compared then.
	always @(negedge clk)
	begin
		while (pin_q.size() > 0)
		begin
			pn = pin_q.pop_front();
			`CHK(pn.nm, pn.lr, {lr_oe, lr_last, lr_first, lr_out})
			`CHK(pn.nm, pn.ro, {ro_oe, ro_last, ro_first, ro_out})
		end
	end
	// Bus answers are compared at the edge where they are taken.
	always @(posedge clk)
	begin
		if (s_axi_bvalid && s_axi_bready)
		begin
			an = b_q.pop_front();
			`CHK(an.nm, an.v, {s_axi_bresp, 32'h0})
		end
		if (s_axi_rvalid && s_axi_rready)
		begin
			an = r_q.pop_front();
			`CHK(an.nm, an.v, {s_axi_rresp, s_axi_rdata})
		end
	end
	////////////////////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then stops.
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	// A wait that ran out counts as a mismatch and ends the run.
	task automatic timeout(input int n);
		if (n >= 100)
		begin
			fail_count++;
			$display("BAD handshake expected answer seen none");
			results();
		end
	endtask : timeout
	// Drives one clocked operation and notes what both variants must show after it.
	task automatic step(input logic [1:0] md, input logic [1:0] g, input logic [3:0] rc,
		input logic cl);
		logic [31:0] rn;
		logic [7:0] nx;
		logic fill;
		rn = $random(seed);
		{mode_select_high, mode_select_low} <= md;
		{bus_drive_ctl_a, bus_drive_ctl_b} <= g;
		{reg_enable_n, serial_select, sign_extend_n, data_select} <= rc;
		clear_n <= cl;
		{fill_bit_one_in, fill_bit_zero_in, right_serial_in, left_serial_in} <= rn[11:8];
		drv_val <= rn[7:0];
		drv_lr <= ~|e_oe_lr;
		drv_ro <= ~|e_oe_ro;
		if (!cl && pin_q.size() > 0)
		begin
			pin_q[$].lr[9:0] = 10'h0;
			pin_q[$].ro[9:0] = 10'h0;
		end
		case (md)
			2'b01: nx = {e_lr[6:0], rn[9]};
			2'b10: nx = {rn[8], e_lr[7:1]};
			2'b11: nx = (|e_oe_lr) ? e_lr : rn[7:0];
			default: nx = e_lr;
		endcase
		if (cap_en && cl && md != 2'b00 && cap_q.size() < 16)
			cap_q.push_back(nx);
		e_lr = cl ? nx : 8'h00;
		e_oe_lr = (g == 2'b00 && md != 2'b11) ? 8'hff : 8'h00;
		fill = !rc[1] ? e_ro[0] : (rc[0] ? rn[11] : rn[10]);
		nx = rc[3] ? e_ro : (rc[2] ? {e_ro[6:0], fill} : ((|e_oe_ro) ? e_ro : rn[7:0]));
		e_ro = cl ? nx : 8'h00;
		e_oe_ro = (g == 2'b00 && rc[3:2] != 2'b00) ? 8'hff : 8'h00;
		@(posedge clk);
		pin_q.push_back('{"pins", {e_oe_lr, e_lr[7], e_lr[0], e_lr}, {e_oe_ro, e_ro[7], e_ro[0], e_ro}});
	endtask : step
	// Writes one register word and notes the expected response.
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] rs);
		int n;
		@(posedge clk);
		b_q.push_back('{"bresp", {rs, 32'h0}});
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			n++;
		end
		while (!s_axi_bvalid && n < 100);
		s_axi_bready <= 1'b0;
		timeout(n);
	endtask : axi_wr
	// Reads one register word and notes the expected response and data.
	task automatic axi_rd(input logic [3:0] a, input logic [33:0] ev);
		int n;
		@(posedge clk);
		r_q.push_back('{"rdata", ev});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			n++;
		end
		while (!s_axi_rvalid && n < 100);
		s_axi_rready <= 1'b0;
		timeout(n);
	endtask : axi_rd
	// Status word expected from the left/right model and the capture count.
	function automatic logic [33:0] stat_exp();
		return {osr_pkg::RESP_OKAY, 11'h0, 5'(cap_q.size()), 4'h0, cap_q.size() < 16,
			e_oe_lr[0], e_lr[7], e_lr[0], e_lr};
	endfunction : stat_exp
	////////////////////////////////////////////////////////////////////////////////////////
	// Main sequence: directed cases, then random traffic that fills the FIFO, then reads that drain it.
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		step(2'b00, 2'b00, 4'b1000, 1'b1);
		axi_rd(osr_pkg::OFF_CTRL, {osr_pkg::RESP_OKAY, 32'h0});
		axi_rd(4'hc, {osr_pkg::RESP_DECERR, 32'h0});
		axi_wr(4'hc, 32'h1, osr_pkg::RESP_DECERR);
		$display("test registers done");
		step(2'b00, 2'b10, 4'b1000, 1'b1);
		step(2'b11, 2'b00, 4'b0000, 1'b1);
		step(2'b00, 2'b00, 4'b1000, 1'b1);
		step(2'b11, 2'b01, 4'b0000, 1'b1);
		#20 clear_n = 1'b0;
		e_lr = 8'h00;
		e_ro = 8'h00;
		pin_q[$].lr[9:0] = 10'h0;
		pin_q[$].ro[9:0] = 10'h0;
		#5 pin_q.push_back('{"async clear", {e_oe_lr, 10'h0}, {e_oe_ro, 10'h0}});
		@(posedge clk);
		step(2'b00, 2'b00, 4'b0000, 1'b0);
		step(2'b00, 2'b00, 4'b1000, 1'b1);
		$display("test directed done");
		axi_wr(osr_pkg::OFF_CTRL, 32'h1, osr_pkg::RESP_OKAY);
		cap_en = 1'b1;
		repeat (48)
		begin
			r = $random(seed);
			step(r[1:0], r[3:2], r[7:4], |r[10:8]);
		end
		step(2'b00, 2'b00, 4'b1000, 1'b1);
		axi_rd(osr_pkg::OFF_CTRL, {osr_pkg::RESP_OKAY, 32'h1});
		axi_rd(osr_pkg::OFF_STATUS, stat_exp());
		while (cap_q.size() > 0)
			axi_rd(osr_pkg::OFF_FIFO, {osr_pkg::RESP_OKAY, 23'h0, 1'b1, cap_q.pop_front()});
		axi_rd(osr_pkg::OFF_FIFO, {osr_pkg::RESP_OKAY, 32'h0});
		axi_rd(osr_pkg::OFF_STATUS, stat_exp());
		axi_wr(osr_pkg::OFF_STATUS, 32'hffffffff, osr_pkg::RESP_OKAY);
		repeat (3) @(posedge clk);
		$display("test capture done");
		results();
	end
endmodule : osr_top_tb
